// File: mmu_pkg.sv
package mmu_pkg;
    // Register port geometry
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;
    localparam int PKT_W_DEF = 6;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_CMD = 3'h0;
    localparam logic [ADDR_W-1:0] OFF_PNR = 3'h2;
    localparam logic [ADDR_W-1:0] OFF_ARR = 3'h3;
    localparam logic [ADDR_W-1:0] OFF_FIFO = 3'h4;

    // Field layout
    localparam int CMD_LSB = 5;
    localparam int CMD_W = 3;
    localparam int BUSY_BIT = 0;
    localparam int FLAG_BIT = 7;
    localparam int BYTE_W = 8;

    // Reset values
    localparam logic FAILED_RST = 1'b1;
    localparam logic EMPTY_RST = 1'b1;

    // Release processing time
    localparam int CLK_PERIOD_NS = 10;
    localparam int RELEASE_TIME_NS = 40;
    localparam int RELEASE_CYCLES = (RELEASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REL_CNT_W = 4;

    // Command codes
    typedef enum logic [CMD_W-1:0] {
        CMD_NOOP = 3'h0,
        CMD_ALLOC = 3'h1,
        CMD_MMU_RESET = 3'h2,
        CMD_RX_POP = 3'h3,
        CMD_RX_POP_FREE = 3'h4,
        CMD_FREE_PKT = 3'h5,
        CMD_TX_ENQ = 3'h6,
        CMD_TX_RESET = 3'h7
    } cmd_t;

    // Release sequencer
    typedef enum logic {REL_IDLE, REL_WAIT} rel_state_t;
endpackage

// File: packet_mmu.sv
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
// Function
// R1: decode command bits: noop, allocate, reset
// R2: software encodes size as 256-byte units minus one
// R3: allocate gives completion code immediately
// R4: size bits ignored; software zeroes them otherwise
// R5: allocator reset frees all, clears queues
// R6: command 3 pops receive queue head
// R7: command 4 pops and frees receive head
// R8: command 5 frees packet in select register
// R9: command 6 enqueues selected packet for transmit
// R10: command 7 empties both transmit queues
// R11: transmit queue reset only with transmitter off
// R12: software recovers packets after transmit reset
// R13: release only packets holding allocated memory
// R14: no new allocate before previous completes
// R15: respect busy flag between release commands
// R16: command address bit 0 reads busy
// R17: busy and failure set after command write
// R18: select register cleared by both resets
// R19: failure flag clear on success, set at reset
// R20: result register holds last allocated number
// R21: queue port shows empty flags and heads
// R22: completion head pops on acknowledge
// R23: allocation done equals inverse of failure
// R24: one command per write, noop ignored
module packet_mmu #(
    parameter int PKT_W = mmu_pkg::PKT_W_DEF
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // Register port
    input wire logic [mmu_pkg::ADDR_W-1:0] ADDR,
    input wire logic [mmu_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [mmu_pkg::DATA_W-1:0] RDATA,
    // Status towards the interrupt logic
    output logic ALLOC_DONE,
    output logic RX_PENDING,
    // Receiver: each completed frame takes a packet number if one is left after the host's allocation, else it fails
    input wire logic RX_FRAME,
    output logic RX_FRAME_OK,
    output logic RX_FRAME_FAIL,
    output logic [PKT_W-1:0] RX_FRAME_NUM,
    // Transmitter: pending queue head and completion push
    output logic TX_PKT_VALID,
    output logic [PKT_W-1:0] TX_PKT_NUM,
    input wire logic TX_PKT_TAKE,
    input wire logic TX_DONE_PUSH,
    input wire logic [PKT_W-1:0] TX_DONE_NUM,
    input wire logic TX_DONE_ACK
);
    import mmu_pkg::*;

    localparam int NUM = 1 << PKT_W;
    localparam logic [PKT_W:0] Q_FULL = {1'b1, {PKT_W{1'b0}}};

    typedef struct packed {
        logic [NUM-1:0][PKT_W-1:0] mem;
        logic [PKT_W-1:0] rd;
        logic [PKT_W-1:0] wr;
        logic [PKT_W:0] count;
        logic empty;
        logic [PKT_W-1:0] head;
    } queue_t;

    typedef struct packed {
        logic [NUM-1:0] used;
        logic [PKT_W-1:0] tx_packet_select;
        logic [PKT_W-1:0] arr_num;
        logic failed;
        logic pending;
        logic busy;
        rel_state_t rel;
        logic [REL_CNT_W-1:0] rel_cnt;
        logic [PKT_W-1:0] rel_num;
        queue_t rx;
        queue_t txq;
        queue_t done;
        logic [DATA_W-1:0] rdata;
        logic alloc_done;
        logic rx_pending;
        logic tx_valid;
        logic [PKT_W-1:0] tx_num;
        logic rx_ok;
        logic rx_fail;
        logic [PKT_W-1:0] rx_num;
    } state_t;

    state_t s;
    state_t n;
    logic cmd_wr;
    cmd_t wcmd;

    // Lowest free packet number, with a found flag on top
    function automatic logic [PKT_W:0] find_free(input logic [NUM-1:0] used);
        logic [PKT_W:0] r;
        r = '0;
        for (int i = NUM - 1; i >= 0; i--) begin
            if (!used[i]) begin
                r = {1'b1, PKT_W'(i)};
            end
        end
        return r;
    endfunction

    // Push drops the number when full; cannot happen for rx, but txq and done take any number, repeats included
    function automatic queue_t q_push(input queue_t q, input logic [PKT_W-1:0] num);
        queue_t r;
        r = q;
        if (q.count != Q_FULL) begin
            r.mem[q.wr] = num;
            r.wr = q.wr + 1'b1;
            r.count = q.count + 1'b1;
        end
        return r;
    endfunction

    function automatic queue_t q_pop(input queue_t q);
        queue_t r;
        r = q;
        if (q.count != '0) begin
            r.rd = q.rd + 1'b1;
            r.count = q.count - 1'b1;
        end
        return r;
    endfunction

    // Pointers only; stale entries are never visible through an empty queue
    function automatic queue_t q_clear(input queue_t q);
        queue_t r;
        r = q;
        r.rd = '0;
        r.wr = '0;
        r.count = '0;
        return r;
    endfunction

    // Registered head and empty flag, so the ports come from flops
    function automatic queue_t q_fix(input queue_t q);
        queue_t r;
        r = q;
        r.empty = (q.count == '0);
        // An empty queue shows number 0, so no stale entry leaks after a clear
        r.head = (q.count == '0) ? '0 : q.mem[q.rd];
        return r;
    endfunction

    // Flag in bit 7, packet number in the low bits
    function automatic logic [BYTE_W-1:0] fmt(input logic flag, input logic [PKT_W-1:0] num);
        logic [BYTE_W-1:0] b;
        b = '0;
        b[FLAG_BIT] = flag;
        b[PKT_W-1:0] = num;
        return b;
    endfunction

    // Command decode; size bits never take part
    assign cmd_wr = WR && (ADDR == OFF_CMD); // R24
    assign wcmd = cmd_t'(WDATA[CMD_LSB +: CMD_W]); // R1 R4

    // Next-state logic
    always_comb begin
        logic [PKT_W:0] f;
        f = '0;
        n = s;
        n.rdata = '0;
        n.rx_ok = 1'b0;
        n.rx_fail = 1'b0;

        // Release in flight: memory is freed when the countdown ends
        if (s.rel == REL_WAIT) begin
            if (s.rel_cnt == '0) begin
                n.used[s.rel_num] = 1'b0; // R7 R8
                n.rel = REL_IDLE;
                n.busy = 1'b0; // R16
            end else begin
                n.rel_cnt = s.rel_cnt - 1'b1;
            end
        end

        // Transmitter side of the queues
        if (TX_PKT_TAKE) begin
            n.txq = q_pop(n.txq);
        end
        if (TX_DONE_ACK) begin
            n.done = q_pop(n.done); // R22
        end
        if (TX_DONE_PUSH) begin
            n.done = q_push(n.done, TX_DONE_NUM);
        end

        // Packet select register write
        if (WR && (ADDR == OFF_PNR)) begin
            n.tx_packet_select = WDATA[PKT_W-1:0];
        end

        // One command per write; flags appear on the edge that ends the write
        if (cmd_wr) begin
            unique case (wcmd)
                CMD_NOOP: begin
                end
                CMD_ALLOC: begin
                    f = find_free(n.used);
                    if (f[PKT_W]) begin
                        n.used[f[PKT_W-1:0]] = 1'b1;
                        n.arr_num = f[PKT_W-1:0]; // R20
                        n.failed = 1'b0; // R3 R19
                        n.pending = 1'b0;
                    end else begin
                        n.failed = 1'b1; // R17 R19
                        n.pending = 1'b1;
                    end
                end
                CMD_MMU_RESET: begin
                    n.used = '0; // R5
                    n.rx = q_clear(n.rx);
                    n.txq = q_clear(n.txq);
                    n.done = q_clear(n.done);
                    n.tx_packet_select = '0; // R18
                    n.failed = FAILED_RST; // R19
                    n.pending = 1'b0;
                    n.rel = REL_IDLE;
                    n.busy = 1'b0;
                end
                CMD_RX_POP: begin
                    n.rx = q_pop(n.rx); // R6
                end
                CMD_RX_POP_FREE: begin
                    if (!s.rx.empty) begin
                        n.rel_num = s.rx.head; // R7
                        n.rel = REL_WAIT;
                        n.rel_cnt = REL_CNT_W'(RELEASE_CYCLES - 1);
                        n.busy = 1'b1; // R17
                    end
                    n.rx = q_pop(n.rx);
                end
                CMD_FREE_PKT: begin
                    n.rel_num = s.tx_packet_select; // R8
                    n.rel = REL_WAIT;
                    n.rel_cnt = REL_CNT_W'(RELEASE_CYCLES - 1);
                    n.busy = 1'b1; // R17
                end
                CMD_TX_ENQ: begin
                    n.txq = q_push(n.txq, s.tx_packet_select); // R9
                end
                CMD_TX_RESET: begin
                    n.txq = q_clear(n.txq); // R10
                    n.done = q_clear(n.done);
                end
            endcase
        end

        // A failed allocation is retried until memory frees up
        if (n.pending) begin
            f = find_free(n.used);
            if (f[PKT_W]) begin
                n.used[f[PKT_W-1:0]] = 1'b1;
                n.arr_num = f[PKT_W-1:0];
                n.failed = 1'b0; // R19
                n.pending = 1'b0;
            end
        end

        // Receive frames take what is left after the host's request
        if (RX_FRAME) begin
            f = find_free(n.used);
            if (f[PKT_W]) begin
                n.used[f[PKT_W-1:0]] = 1'b1;
                n.rx = q_push(n.rx, f[PKT_W-1:0]);
                n.rx_ok = 1'b1;
                n.rx_num = f[PKT_W-1:0];
            end else begin
                n.rx_fail = 1'b1;
            end
        end

        // Register reads, answered in the next cycle
        if (RD) begin
            unique case (ADDR)
                OFF_CMD: n.rdata[BUSY_BIT] = s.busy; // R16
                OFF_PNR: n.rdata[BYTE_W-1:0] = fmt(1'b0, s.tx_packet_select);
                OFF_ARR: n.rdata[BYTE_W-1:0] = fmt(s.failed, s.arr_num); // R20
                OFF_FIFO: n.rdata = {fmt(s.rx.empty, s.rx.head), fmt(s.done.empty, s.done.head)}; // R21
                default: n.rdata = '0;
            endcase
        end

        n.rx = q_fix(n.rx);
        n.txq = q_fix(n.txq);
        n.done = q_fix(n.done);
        n.alloc_done = ~n.failed; // R23
        n.rx_pending = ~n.rx.empty;
        n.tx_valid = ~n.txq.empty;
        n.tx_num = n.txq.head;

        // Synchronous reset overrides everything
        if (RST) begin
            n = '0;
            n.failed = FAILED_RST; // R19
            n.rx.empty = EMPTY_RST; // R21
            n.txq.empty = EMPTY_RST;
            n.done.empty = EMPTY_RST;
            n.rel = REL_IDLE;
        end
    end

    // State register
    always_ff @(posedge REF_CLK) begin
        s <= n;
    end

    // Outputs straight from state
    assign RDATA = s.rdata;
    assign ALLOC_DONE = s.alloc_done;
    assign RX_PENDING = s.rx_pending;
    assign RX_FRAME_OK = s.rx_ok;
    assign RX_FRAME_FAIL = s.rx_fail;
    assign RX_FRAME_NUM = s.rx_num;
    assign TX_PKT_VALID = s.tx_valid;
    assign TX_PKT_NUM = s.tx_num;

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    alloc_ok_a: assert property (cmd_wr && wcmd == CMD_ALLOC && !(&s.used) |=> !s.failed && s.used[s.arr_num]) else $error("allocation with free memory failed"); // R3
    alloc_done_a: assert property (##1 s.alloc_done != s.failed) else $error("allocation done not inverse of failed"); // R23
    mmu_reset_a: assert property (cmd_wr && wcmd == CMD_MMU_RESET |=> s.failed && s.tx_packet_select == '0 && (s.rx.empty || $past(RX_FRAME)) && !s.busy) else $error("allocator reset incomplete"); // R5
    busy_set_a: assert property (cmd_wr && wcmd == CMD_FREE_PKT |=> s.busy ##1 s.busy) else $error("busy not set by release"); // R17
    busy_len_a: assert property ($rose(s.busy) |-> s.busy [*4] ##1 !s.busy) else $error("busy length wrong"); // R16
    free_done_a: assert property ($fell(s.busy) && !s.rx_ok && !$past(s.pending) |-> !s.used[s.rel_num]) else $error("released packet still allocated"); // R8
    rx_free_a: assert property (cmd_wr && wcmd == CMD_RX_POP_FREE && !s.rx.empty // R7
        |=> s.busy && s.rel_num == $past(s.rx.head)) else $error("receive release not started");
    noop_a: assert property (cmd_wr && wcmd == CMD_NOOP && !RX_FRAME && !s.busy && !s.pending // R24
        |=> s.used == $past(s.used) && s.arr_num == $past(s.arr_num)) else $error("noop changed state");
    tx_enq_a: assert property (cmd_wr && wcmd == CMD_TX_ENQ && !TX_PKT_TAKE && s.txq.count != Q_FULL |=> s.txq.count == $past(s.txq.count) + 1'b1) else $error("enqueue lost"); // R9
    tx_reset_a: assert property (cmd_wr && wcmd == CMD_TX_RESET |=> s.txq.empty && s.done.empty && !s.tx_valid) else $error("transmit queues not emptied"); // R10
    rx_pop_a: assert property (cmd_wr && wcmd == CMD_RX_POP && !s.rx.empty && !RX_FRAME |=> s.rx.count == $past(s.rx.count) - 1'b1 && s.used == $past(s.used)) else $error("rx pop wrong"); // R6
    fifo_read_a: assert property (RD && ADDR == OFF_FIFO |=> RDATA[DATA_W-1] == $past(s.rx.empty) && RDATA[FLAG_BIT] == $past(s.done.empty)) else $error("queue port flags wrong"); // R21
    done_pop_a: assert property (TX_DONE_ACK && !s.done.empty && !TX_DONE_PUSH && !cmd_wr |=> s.done.count == $past(s.done.count) - 1'b1) else $error("completion pop lost"); // R22
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
    import mmu_pkg::*;
    // Stimulus and observed signals
    logic REF_CLK = 1'b0;
    logic RST = 1'b1;
    logic [ADDR_W-1:0] ADDR = 3'h0;
    logic [DATA_W-1:0] WDATA = 16'h0000;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [DATA_W-1:0] RDATA;
    logic ALLOC_DONE, RX_PENDING, RX_FRAME_OK, RX_FRAME_FAIL, TX_PKT_VALID;
    logic [5:0] RX_FRAME_NUM, TX_PKT_NUM;
    logic [3:0] pulses = 4'h0;
    logic [5:0] TX_DONE_NUM = 6'h00;
    int mismatches = 0;
    int compares = 0;

    packet_mmu u_dut (
        .REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .ALLOC_DONE(ALLOC_DONE), .RX_PENDING(RX_PENDING),
        .RX_FRAME(pulses[3]), .RX_FRAME_OK(RX_FRAME_OK), .RX_FRAME_FAIL(RX_FRAME_FAIL),
        .RX_FRAME_NUM(RX_FRAME_NUM), .TX_PKT_VALID(TX_PKT_VALID), .TX_PKT_NUM(TX_PKT_NUM),
        .TX_PKT_TAKE(pulses[2]), .TX_DONE_PUSH(pulses[1]), .TX_DONE_NUM(TX_DONE_NUM),
        .TX_DONE_ACK(pulses[0])
    );

    // 100 MHz clock
    always #5 REF_CLK = ~REF_CLK;

    // Register write: one strobe cycle, then settle past the edge
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge REF_CLK);
        WR <= 1'b0;
        #1;
    endtask

    // Word compare; four-state equality so an unknown matches only an unknown
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Single-bit compare
    task automatic chkb(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask

    // Register read; data is taken in the one cycle it stands
    task automatic rchk(input logic [2:0] a, input logic [15:0] exp, input string what);
        @(posedge REF_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge REF_CLK);
        RD <= 1'b0;
        #1;
        chk(RDATA, exp, what);
    endtask

    // One-cycle pulse on receiver/transmitter inputs {frame, take, push, ack}
    task automatic pulse(input logic [3:0] sel);
        @(posedge REF_CLK);
        pulses <= sel;
        @(posedge REF_CLK);
        pulses <= 4'h0;
        #1;
    endtask

    task automatic t_reset;
        rchk(OFF_ARR, 16'h0080, "arr reset");
        rchk(OFF_FIFO, 16'h8080, "fifo reset");
        rchk(OFF_PNR, 16'h0000, "select reset");
        rchk(OFF_CMD, 16'h0000, "busy reset");
        rchk(3'h1, 16'h0000, "unmapped read");
        chkb(ALLOC_DONE, 1'b0, "done at reset");
        $display("test reset done");
    endtask

    task automatic t_alloc;
        wr(OFF_CMD, 16'h0040);
        wr(OFF_CMD, 16'h0020);
        rchk(OFF_ARR, 16'h0000, "first alloc");
        chkb(ALLOC_DONE, 1'b1, "done after alloc");
        wr(OFF_CMD, 16'h0027);
        rchk(OFF_ARR, 16'h0001, "size bits ignored");
        wr(OFF_CMD, 16'h0007);
        rchk(OFF_ARR, 16'h0001, "noop leaves result");
        $display("test alloc done");
    endtask

    task automatic t_tx;
        wr(OFF_CMD, 16'h0040);
        wr(OFF_CMD, 16'h0020);
        wr(OFF_CMD, 16'h0020);
        wr(OFF_PNR, 16'h0001);
        wr(OFF_CMD, 16'h00C0);
        chkb(TX_PKT_VALID, 1'b1, "enqueued valid");
        chk({10'h000, TX_PKT_NUM}, 16'h0001, "enqueued number");
        pulse(4'h4);
        chkb(TX_PKT_VALID, 1'b0, "taken");
        TX_DONE_NUM <= 6'h01;
        pulse(4'h2);
        rchk(OFF_FIFO, 16'h8001, "done head");
        pulse(4'h1);
        rchk(OFF_FIFO, 16'h8080, "done popped");
        wr(OFF_CMD, 16'h00C0);
        pulse(4'h2);
        wr(OFF_CMD, 16'h00E0);
        chkb(TX_PKT_VALID, 1'b0, "tx reset pending");
        rchk(OFF_FIFO, 16'h8080, "tx reset done queue");
        wr(OFF_CMD, 16'h0020);
        rchk(OFF_ARR, 16'h0002, "tx reset keeps memory");
        $display("test transmit done");
    endtask

    task automatic t_rx;
        wr(OFF_CMD, 16'h0040);
        pulse(4'h8);
        chkb(RX_FRAME_OK, 1'b1, "rx frame granted");
        chk({10'h000, RX_FRAME_NUM}, 16'h0000, "rx frame number");
        pulse(4'h8);
        chk({10'h000, RX_FRAME_NUM}, 16'h0001, "second rx number");
        chkb(RX_PENDING, 1'b1, "rx pending");
        rchk(OFF_FIFO, 16'h0080, "rx head");
        wr(OFF_CMD, 16'h0060);
        rchk(OFF_FIFO, 16'h0180, "rx pop");
        wr(OFF_CMD, 16'h0080);
        rchk(OFF_CMD, 16'h0001, "busy set");
        repeat (4) @(posedge REF_CLK);
        rchk(OFF_CMD, 16'h0000, "busy clear");
        rchk(OFF_FIFO, 16'h8080, "rx empty");
        chkb(RX_PENDING, 1'b0, "rx not pending");
        wr(OFF_CMD, 16'h0020);
        rchk(OFF_ARR, 16'h0001, "only popped-freed reused");
        $display("test receive done");
    endtask

    task automatic t_full;
        wr(OFF_CMD, 16'h0040);
        for (int i = 0; i < 65; i++) begin
            wr(OFF_CMD, 16'h0020);
        end
        chkb(ALLOC_DONE, 1'b0, "alloc failed");
        chkb(u_dut.RDATA[FLAG_BIT], 1'b0, "idle rdata");
        pulse(4'h8);
        chkb(RX_FRAME_FAIL, 1'b1, "fail pulse stands");
        @(posedge REF_CLK);
        #1;
        chkb(RX_FRAME_FAIL, 1'b0, "fail pulse one cycle");
        wr(OFF_PNR, 16'h0005);
        wr(OFF_CMD, 16'h00A0);
        repeat (8) @(posedge REF_CLK);
        rchk(OFF_ARR, 16'h0005, "pending granted");
        chkb(ALLOC_DONE, 1'b1, "done after grant");
        wr(OFF_CMD, 16'h0040);
        rchk(OFF_ARR, 16'h0085, "mmu reset failed");
        rchk(OFF_PNR, 16'h0000, "mmu reset select");
        rchk(OFF_FIFO, 16'h8080, "mmu reset queues");
        $display("test full pool done");
    endtask

    // Verdict in one place
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Main sequence: reset held four cycles, released at an edge
    initial begin
        repeat (4) @(posedge REF_CLK);
        RST <= 1'b0;
        #1;
        t_reset();
        t_alloc();
        t_tx();
        t_rx();
        t_full();
        tally_and_finish();
    end

    // Watchdog: a hang counts as a mismatch
    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end
endmodule
